/* File: shared/fnd_pkg.sv */
// Constants, types and field layouts of the fractional-N divider control core
package fnd_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned LOCK_WIN_NS   = 250;
    // Longest time: round down, never below one cycle
    localparam int unsigned LOCK_WIN_CYC_I =
        (LOCK_WIN_NS / CLK_PERIOD_NS) < 1 ? 1 : (LOCK_WIN_NS / CLK_PERIOD_NS);
    localparam logic [3:0]  LOCK_WIN_CYC  = LOCK_WIN_CYC_I[3:0];
    localparam logic [2:0]  LOCK_CMP_NEED = 3'h7;

    // ------------------------------------------------------------------
    // Divider widths and ratios
    // ------------------------------------------------------------------
    localparam int unsigned DIV_W   = 14;
    localparam int unsigned EFF_W   = 15;
    localparam int unsigned N_LSB   = 2;
    localparam int unsigned N_MSB   = 14;

    // Reference ratio per {sel_a, sel_b}; effective ratio is four times these
    localparam logic [DIV_W-1:0] REF_RATIO_00 = 14'h0118;  // 280
    localparam logic [DIV_W-1:0] REF_RATIO_10 = 14'h0120;  // 288
    localparam logic [DIV_W-1:0] REF_RATIO_01 = 14'h0100;  // 256
    localparam logic [DIV_W-1:0] REF_RATIO_11 = 14'h0180;  // 384

    // Legal effective main ratio range, kept by the host model only; the core does not guard it
    localparam logic [EFF_W-1:0] EFF_MIN = 15'h0800;
    localparam logic [EFF_W-1:0] EFF_MAX = 15'h7FFF;

    // Pump current code {msb, lsb}: 00=50, 01=102, 10=151, 11=203 uA nominal
    localparam logic [1:0] PUMP_CUR_RST = 2'h0;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic             ref_ratio_sel_a;
        logic             ref_ratio_sel_b;
        logic [EFF_W-1:0] eff_ratio;
    } fnd_div_cfg_s;

    typedef struct packed {
        logic filter_amp_off;
        logic test_mode;
        logic pump_disable;
        logic pump_current_msb;
        logic pump_current_lsb;
        logic sw_c;
        logic sw_d;
        logic sw_e;
        logic sw_f;
        logic sw_g;
        logic sw_h;
    } fnd_ctl_cfg_s;

    typedef struct packed {
        logic source;
        logic sink;
    } fnd_pump_s;

    localparam fnd_div_cfg_s DIV_CFG_RST = '0;
    localparam fnd_ctl_cfg_s CTL_CFG_RST = '0;

    typedef enum logic [1:0] {
        PFD_IDLE = 2'b00,
        PFD_SRC  = 2'b01,
        PFD_SNK  = 2'b10
    } fnd_pfd_e;

endpackage

/* File: verilog/fnd_edge_div.sv */
// Synchronised edge-counting programmable divider
`timescale 1ns/1ps
module fnd_edge_div
    import fnd_pkg::*;
(
    input  wire logic             mclk_i,
    input  wire logic             rstn_i,
    input  wire logic             hold_i,
    input  wire logic             sig_i,
    input  wire logic [DIV_W-1:0] ratio_i,
    output logic                  pulse_o
);

    logic [2:0]       sync_ff;
    logic [DIV_W-1:0] cnt_ff;
    logic             rise;

    // ------------------------------------------------------------------
    // Two-stage synchroniser, edge found on the later stages only
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sync_ff <= 3'h0;
        end else begin
            sync_ff <= {sync_ff[1:0], sig_i};
        end
    end

    assign rise = sync_ff[1] & ~sync_ff[2];

    // ------------------------------------------------------------------
    // Counter: one pulse every ratio_i input edges
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_ff  <= '0;
            pulse_o <= 1'b0;
        end else if (hold_i) begin
            cnt_ff  <= '0;
            pulse_o <= 1'b0;
        end else if (rise) begin
            if (cnt_ff >= ratio_i - DIV_W'(1)) begin
                cnt_ff  <= '0;
                pulse_o <= 1'b1;
            end else begin
                cnt_ff  <= cnt_ff + DIV_W'(1);
                pulse_o <= 1'b0;
            end
        end else begin
            pulse_o <= 1'b0;
        end
    end

endmodule

/* File: verilog/fnd_core.sv */
// Fractional-N divider control core: dividers, phase detector, pump, lock, switches
//
// Functional notes
// - Reference divided by one of four selectable ratios
// - Comparison grid is four times channel step
// - Main divider divides by N or N+1
// - N+1 chosen k of four cycles
// - Test bit routes divided signals to C, F
// - Dividers held reset until ratio first written
// - Divider setting applied after transfer completes
// - Divider change applied only while pump idle
// - Phase detector drives source, sink or idle
// - Four pump current levels from two bits
// - Pump disable forces pump output off
// - Current change applied after transfer, pump idle
// - Amplifier-off bit disables loop amplifier output
// - Lock after seven in-window comparisons
// - Lock flag output high while locked
// - Pump disable deactivates lock detector
// - Six switch outputs follow own control bits; C and F only while the test bit is clear
// - Ratio select encoding 00,10,01,11 mapping
// - Pump current code maps 50 to 203 uA
// - Bytes arrive in ascending order, none skipped
// - Switch bit high turns output current on
`timescale 1ns/1ps
module fnd_core
    import fnd_pkg::*;
(
    input  wire logic         mclk_i,
    input  wire logic         rstn_i,
    input  wire logic         ref_in_i,
    input  wire logic         rf_in_i,
    input  wire fnd_div_cfg_s div_cfg_i,
    input  wire logic         div_wr_i,
    input  wire fnd_ctl_cfg_s ctl_cfg_i,
    input  wire logic         ctl_wr_i,
    output fnd_pump_s         pump_output_o,
    output logic [1:0]        pump_current_o,
    output logic              loop_amp_output_en_o,
    output logic              lock_flag_out_o,
    output logic              switch_out_c_o,
    output logic              switch_out_d_o,
    output logic              switch_out_e_o,
    output logic              switch_out_f_o,
    output logic              switch_out_g_o,
    output logic              switch_out_h_o,
    output logic              div_running_o,
    output logic              update_pending_o
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    fnd_div_cfg_s     div_pend_ff;
    logic             div_pend_vld_ff;
    fnd_div_cfg_s     div_act_ff;
    logic             div_run_ff;
    logic [1:0]       cur_pend_ff;
    logic             cur_pend_vld_ff;
    logic [1:0]       cur_act_ff;
    fnd_ctl_cfg_s     ctl_ff;
    fnd_pfd_e         pfd_ff;
    fnd_pfd_e         nxt_pfd;
    logic             ref_pulse;
    logic             main_pulse;
    logic             pump_quiet;
    logic [DIV_W-1:0] ref_ratio;
    logic [DIV_W-1:0] main_ratio;
    logic [1:0]       frac_acc_ff;
    logic             plus_one_ff;
    logic [2:0]       nxt_frac_sum;
    logic [3:0]       width_ff;
    logic [2:0]       good_cnt_ff;
    logic             cmp_done;
    logic             win_exceeded;
    logic             lock_ff;
    logic             ref_mon_ff;
    logic             main_mon_ff;
    fnd_pump_s        nxt_pump;

    // ------------------------------------------------------------------
    // Ratio decoding
    // ------------------------------------------------------------------
    // Grid at four times the step; fractional sequencing makes the step
    always_comb begin
        case ({div_act_ff.ref_ratio_sel_a, div_act_ff.ref_ratio_sel_b})
            2'b00:   ref_ratio = REF_RATIO_00;
            2'b10:   ref_ratio = REF_RATIO_10;
            2'b01:   ref_ratio = REF_RATIO_01;
            2'b11:   ref_ratio = REF_RATIO_11;
            default: ref_ratio = REF_RATIO_00;
        endcase
    end

    // Base N is the upper 13 bits; ratios below EFF_MIN are not guarded
    assign main_ratio = DIV_W'(div_act_ff.eff_ratio[N_MSB:N_LSB])
                      + DIV_W'(plus_one_ff);

    // ------------------------------------------------------------------
    // Dividers
    // ------------------------------------------------------------------
    fnd_edge_div u_ref_div (
        .mclk_i  (mclk_i),
        .rstn_i  (rstn_i),
        .hold_i  (~div_run_ff),
        .sig_i   (ref_in_i),
        .ratio_i (ref_ratio),
        .pulse_o (ref_pulse)
    );

    fnd_edge_div u_main_div (
        .mclk_i  (mclk_i),
        .rstn_i  (rstn_i),
        .hold_i  (~div_run_ff),
        .sig_i   (rf_in_i),
        .ratio_i (main_ratio),
        .pulse_o (main_pulse)
    );

    // ------------------------------------------------------------------
    // Fractional sequencer
    // ------------------------------------------------------------------
    // Accumulator carry picks N+1 for k of every four main cycles
    assign nxt_frac_sum = {1'b0, frac_acc_ff}
                        + {1'b0, div_act_ff.eff_ratio[N_LSB-1:0]};

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            frac_acc_ff <= 2'h0;
            plus_one_ff <= 1'b0;
        end else if (!div_run_ff) begin
            frac_acc_ff <= 2'h0;
            plus_one_ff <= 1'b0;
        end else if (main_pulse) begin
            frac_acc_ff <= nxt_frac_sum[1:0];
            plus_one_ff <= nxt_frac_sum[2];
        end
    end

    // ------------------------------------------------------------------
    // Tri-state phase detector
    // ------------------------------------------------------------------
    always_comb begin
        nxt_pfd = pfd_ff;
        case (pfd_ff)
            PFD_IDLE: begin
                if (ref_pulse && !main_pulse) begin
                    nxt_pfd = PFD_SRC;
                end else if (main_pulse && !ref_pulse) begin
                    nxt_pfd = PFD_SNK;
                end
            end
            PFD_SRC: begin
                if (main_pulse) begin
                    nxt_pfd = PFD_IDLE;
                end
            end
            PFD_SNK: begin
                if (ref_pulse) begin
                    nxt_pfd = PFD_IDLE;
                end
            end
            default: nxt_pfd = PFD_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pfd_ff <= PFD_IDLE;
        end else if (!div_run_ff) begin
            pfd_ff <= PFD_IDLE;
        end else begin
            pfd_ff <= nxt_pfd;
        end
    end

    // Quiet now and not about to start this cycle
    assign pump_quiet = (pfd_ff == PFD_IDLE) && (nxt_pfd == PFD_IDLE);

    always_comb begin
        nxt_pump.source = (nxt_pfd == PFD_SRC) && !ctl_ff.pump_disable;
        nxt_pump.sink   = (nxt_pfd == PFD_SNK) && !ctl_ff.pump_disable;
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pump_output_o <= '0;
        end else begin
            pump_output_o <= nxt_pump;
        end
    end

    // ------------------------------------------------------------------
    // Divider setting: pending copy, applied at a quiet pump moment
    // ------------------------------------------------------------------
    // Write strobe marks the end of a whole transfer, bytes in order
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            div_pend_ff     <= DIV_CFG_RST;
            div_pend_vld_ff <= 1'b0;
        end else if (div_wr_i) begin
            // New write stays pending; a same-cycle apply still takes the old pending copy
            div_pend_ff     <= div_cfg_i;
            div_pend_vld_ff <= 1'b1;
        end else if (div_pend_vld_ff && (pump_quiet || !div_run_ff)) begin
            div_pend_vld_ff <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            div_act_ff <= DIV_CFG_RST;
            div_run_ff <= 1'b0;
        end else if (div_pend_vld_ff && (pump_quiet || !div_run_ff)) begin
            div_act_ff <= div_pend_ff;
            div_run_ff <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Pump current: divider's pending scheme, but nothing applied in a write cycle
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cur_pend_ff     <= PUMP_CUR_RST;
            cur_pend_vld_ff <= 1'b0;
        end else if (ctl_wr_i) begin
            cur_pend_ff     <= {ctl_cfg_i.pump_current_msb,
                                ctl_cfg_i.pump_current_lsb};
            cur_pend_vld_ff <= 1'b1;
        end else if (cur_pend_vld_ff && pump_quiet) begin
            cur_pend_vld_ff <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cur_act_ff <= PUMP_CUR_RST;
        end else if (cur_pend_vld_ff && !ctl_wr_i && pump_quiet) begin
            cur_act_ff <= cur_pend_ff;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pump_current_o <= PUMP_CUR_RST;
        end else begin
            pump_current_o <= cur_act_ff;
        end
    end

    // ------------------------------------------------------------------
    // Control bits that take effect at once
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctl_ff <= CTL_CFG_RST;
        end else if (ctl_wr_i) begin
            ctl_ff <= ctl_cfg_i;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            loop_amp_output_en_o <= 1'b0;
        end else begin
            loop_amp_output_en_o <= !ctl_ff.filter_amp_off;
        end
    end

    // ------------------------------------------------------------------
    // Lock detector
    // ------------------------------------------------------------------
    // Width counted while the pump would be active, saturating
    assign cmp_done     = (pfd_ff != PFD_IDLE) && (nxt_pfd == PFD_IDLE);
    assign win_exceeded = (pfd_ff != PFD_IDLE) && (width_ff >= LOCK_WIN_CYC);

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            width_ff <= 4'h0;
        end else if (pfd_ff == PFD_IDLE || cmp_done) begin
            width_ff <= 4'h0;
        end else if (width_ff != 4'hF) begin
            width_ff <= width_ff + 4'h1;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            good_cnt_ff <= 3'h0;
            lock_ff     <= 1'b0;
        end else if (ctl_ff.pump_disable || !div_run_ff) begin
            good_cnt_ff <= 3'h0;
            lock_ff     <= 1'b0;
        end else if (win_exceeded) begin
            good_cnt_ff <= 3'h0;
            lock_ff     <= 1'b0;
        end else if (cmp_done || (ref_pulse && main_pulse)) begin
            if (good_cnt_ff >= LOCK_CMP_NEED - 3'h1) begin
                good_cnt_ff <= LOCK_CMP_NEED;
                lock_ff     <= 1'b1;
            end else begin
                good_cnt_ff <= good_cnt_ff + 3'h1;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lock_flag_out_o <= 1'b0;
        end else begin
            lock_flag_out_o <= lock_ff;
        end
    end

    // ------------------------------------------------------------------
    // Switch outputs and test monitors
    // ------------------------------------------------------------------
    // Monitors toggle per divided period: a one-cycle pulse is too short
    // to be seen off chip
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ref_mon_ff  <= 1'b0;
            main_mon_ff <= 1'b0;
        end else begin
            ref_mon_ff  <= ref_mon_ff ^ ref_pulse;
            main_mon_ff <= main_mon_ff ^ main_pulse;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            switch_out_c_o <= 1'b0;
            switch_out_d_o <= 1'b0;
            switch_out_e_o <= 1'b0;
            switch_out_f_o <= 1'b0;
            switch_out_g_o <= 1'b0;
            switch_out_h_o <= 1'b0;
        end else begin
            switch_out_c_o <= ctl_ff.test_mode ? ref_mon_ff : ctl_ff.sw_c;
            switch_out_d_o <= ctl_ff.sw_d;
            switch_out_e_o <= ctl_ff.sw_e;
            switch_out_f_o <= ctl_ff.test_mode ? main_mon_ff : ctl_ff.sw_f;
            switch_out_g_o <= ctl_ff.sw_g;
            switch_out_h_o <= ctl_ff.sw_h;
        end
    end

    // ------------------------------------------------------------------
    // Status
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            div_running_o    <= 1'b0;
            update_pending_o <= 1'b0;
        end else begin
            div_running_o    <= div_run_ff;
            update_pending_o <= div_pend_vld_ff | cur_pend_vld_ff;
        end
    end

endmodule

/* File: verification/fnd_host_model.sv */
// Host model: hands the core complete divider and control transfers
`timescale 1ns/1ps
module fnd_host_model
    import fnd_pkg::*;
(
    input  wire logic    mclk_i,
    output fnd_div_cfg_s div_cfg_o,
    output logic         div_wr_o,
    output fnd_ctl_cfg_s ctl_cfg_o,
    output logic         ctl_wr_o
);
    // ------------------------------------------------------------------
    // Transfers
    // ------------------------------------------------------------------
    initial begin
        div_cfg_o = DIV_CFG_RST;
        div_wr_o  = 1'b0;
        ctl_cfg_o = CTL_CFG_RST;
        ctl_wr_o  = 1'b0;
    end
    // Strobe once every byte is in; data scrambled outside the strobe
    task automatic send_div(input logic a, input logic b, input logic [EFF_W-1:0] eff);
        if (eff >= EFF_MIN) begin
            @(negedge mclk_i);
            div_cfg_o = {a, b, eff};
            div_wr_o  = 1'b1;
            @(negedge mclk_i);
            div_wr_o  = 1'b0;
            div_cfg_o = ~div_cfg_o;
        end
    endtask
    task automatic send_ctl(input fnd_ctl_cfg_s cfg);
        @(negedge mclk_i);
        ctl_cfg_o = cfg;
        ctl_wr_o  = 1'b1;
        @(negedge mclk_i);
        ctl_wr_o  = 1'b0;
        ctl_cfg_o = ~ctl_cfg_o;
    endtask
endmodule

/* File: verification/fnd_core_sva.sv */
// Port-level checks of the divider control core
`timescale 1ns/1ps
module fnd_core_sva
    import fnd_pkg::*;
(
    input wire logic         mclk_i,
    input wire logic         rstn_i,
    input wire logic         div_wr_i,
    input wire fnd_ctl_cfg_s ctl_cfg_i,
    input wire logic         ctl_wr_i,
    input wire fnd_pump_s    pump_output_o,
    input wire logic [1:0]   pump_current_o,
    input wire logic         loop_amp_output_en_o,
    input wire logic         lock_flag_out_o,
    input wire logic         switch_out_c_o,
    input wire logic         switch_out_d_o,
    input wire logic         switch_out_e_o,
    input wire logic         switch_out_f_o,
    input wire logic         switch_out_g_o,
    input wire logic         switch_out_h_o,
    input wire logic         div_running_o,
    input wire logic         update_pending_o
);
    // ------------------------------------------------------------------
    // Helper state
    // ------------------------------------------------------------------
    fnd_ctl_cfg_s cap_ff;
    logic [2:0]   wr_sh_ff;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    // Reset counts as a write of defaults, so settle time applies after it too
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cap_ff   <= CTL_CFG_RST;
            wr_sh_ff <= 3'h7;
        end else begin
            wr_sh_ff <= {wr_sh_ff[1:0], ctl_wr_i};
            if (ctl_wr_i) begin
                cap_ff <= ctl_cfg_i;
            end
        end
    end
    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_pump_one_hot: assert property (!(pump_output_o.source && pump_output_o.sink))
        else $error("pump sources and sinks at once");
    a_hold_idle: assert property (!div_running_o |->
        pump_output_o == 2'h0 && !lock_flag_out_o)
        else $error("pump or lock active before dividers run");
    a_run_start: assert property ($rose(div_running_o) |->
        $past(div_wr_i, 2) || $past(div_wr_i, 3))
        else $error("dividers started without a divider transfer");
    a_pend_after_wr: assert property (div_wr_i |-> ##[2:3] update_pending_o)
        else $error("divider transfer not marked pending");
    a_switch_follow: assert property (wr_sh_ff == 3'h0 |->
        {switch_out_d_o, switch_out_e_o, switch_out_g_o, switch_out_h_o} ==
        {cap_ff.sw_d, cap_ff.sw_e, cap_ff.sw_g, cap_ff.sw_h} && (cap_ff.test_mode ||
        {switch_out_c_o, switch_out_f_o} == {cap_ff.sw_c, cap_ff.sw_f}))
        else $error("switch outputs differ from written bits");
    a_amp_follow: assert property (wr_sh_ff == 3'h0 |->
        loop_amp_output_en_o == !cap_ff.filter_amp_off)
        else $error("amplifier enable differs from written bit");
    a_disable_off: assert property (wr_sh_ff == 3'h0 && cap_ff.pump_disable |->
        pump_output_o == 2'h0 && !lock_flag_out_o)
        else $error("pump or lock active while pump disabled");
    a_cur_quiet: assert property ($changed(pump_current_o) |->
        $past(pump_output_o) == 2'h0)
        else $error("pump current changed while pump active");
    a_wide_unlock: assert property ((pump_output_o != 2'h0)[*3] |->
        ##[0:2] !lock_flag_out_o)
        else $error("lock kept through wide phase error");
endmodule
bind fnd_core fnd_core_sva i_fnd_core_sva (
    .mclk_i, .rstn_i, .div_wr_i, .ctl_cfg_i, .ctl_wr_i, .pump_output_o, .pump_current_o,
    .loop_amp_output_en_o, .lock_flag_out_o, .switch_out_c_o, .switch_out_d_o,
    .switch_out_e_o, .switch_out_f_o, .switch_out_g_o, .switch_out_h_o, .div_running_o,
    .update_pending_o
);

/* File: verification/fnd_core_tb_top.sv */
// Self-checking bench for the divider control core
`timescale 1ns/1ps
module fnd_core_tb_top;
    import fnd_pkg::*;
    logic         mclk_i = 1'b0;
    logic         rstn_i = 1'b0;
    logic         ref_in_i = 1'b0;
    logic         rf_in_i = 1'b0;
    logic         gen_en = 1'b1;
    logic [2:0]   ph_ff = 3'h0;
    logic [2:0]   ph_rf;
    fnd_div_cfg_s div_cfg_i;
    fnd_ctl_cfg_s ctl_cfg_i;
    fnd_ctl_cfg_s cfg;
    fnd_pump_s    pump;
    logic         div_wr_i, ctl_wr_i, amp_en, lock, running, pending;
    logic [1:0]   cur;
    logic [5:0]   sw;
    int           fails = 0;
    int           comparisons = 0;
    int           gap;
    int           sum;
    logic [1:0]   sel_tab [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
    int           eff_tab [4] = '{1120, 1152, 1536, 1024};
    logic [5:0]   pat_tab [4] = '{6'h15, 6'h2A, 6'h3F, 6'h00};

    fnd_host_model i_fnd_host_model (.mclk_i, .div_cfg_o(div_cfg_i), .div_wr_o(div_wr_i),
        .ctl_cfg_o(ctl_cfg_i), .ctl_wr_o(ctl_wr_i));
    fnd_core i_fnd_core (.mclk_i, .rstn_i, .ref_in_i, .rf_in_i, .div_cfg_i, .div_wr_i,
        .ctl_cfg_i, .ctl_wr_i, .pump_output_o(pump), .pump_current_o(cur),
        .loop_amp_output_en_o(amp_en), .lock_flag_out_o(lock), .switch_out_c_o(sw[5]),
        .switch_out_d_o(sw[4]), .switch_out_e_o(sw[3]), .switch_out_f_o(sw[2]),
        .switch_out_g_o(sw[1]), .switch_out_h_o(sw[0]), .div_running_o(running),
        .update_pending_o(pending));

    // ------------------------------------------------------------------
    // Clock and link inputs
    // ------------------------------------------------------------------
    initial begin
        forever #50 mclk_i = ~mclk_i;
    end
    // Ref at 800 ns, rf at half; rf leads by one period so ratio 2048 pulses coincide
    assign ph_rf = ph_ff + 3'h2;
    always @(negedge mclk_i) begin
        ref_in_i <= gen_en & ph_ff[2];
        rf_in_i  <= gen_en & ph_rf[1];
        ph_ff    <= gen_en ? ph_ff + 3'h1 : 3'h0;
    end

    // ------------------------------------------------------------------
    // Checks and waits
    // ------------------------------------------------------------------
    task automatic wrap_up();
        if (fails == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk_bit(input string what, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic chk_num(input string what, input int exp, input int got);
        comparisons++;
        if (got != exp) begin
            fails++;
            $display("Error %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic wait_toggle(input int idx, output int cyc);
        logic start;
        start = sw[idx];
        cyc = 0;
        while (sw[idx] === start) begin
            @(negedge mclk_i);
            cyc++;
            if (cyc > 20000) begin
                fails++;
                wrap_up();
            end
        end
    endtask
    task automatic settle();
        int n;
        n = 0;
        repeat (4) @(negedge mclk_i);
        while (pending !== 1'b0) begin
            @(negedge mclk_i);
            n++;
            if (n > 20000) begin
                fails++;
                wrap_up();
            end
        end
    endtask

    initial begin
        repeat (20) @(negedge mclk_i);
        rstn_i = 1'b1;
        repeat (100) @(negedge mclk_i);
        chk_bit("div_running", 1'b0, running);
        chk_bit("pump_idle", 1'b1, pump === 2'h0);
        cfg = CTL_CFG_RST;
        cfg.test_mode = 1'b1;
        i_fnd_host_model.send_ctl(cfg);
        for (int i = 0; i < 4; i++) begin
            i_fnd_host_model.send_div(sel_tab[i][1], sel_tab[i][0], 15'h0800);
            settle();
            wait_toggle(5, gap);
            wait_toggle(5, gap);
            chk_num("ref_gap", eff_tab[i] * 2, gap);
        end
        for (int k = 0; k < 4; k++) begin
            i_fnd_host_model.send_div(1'b0, 1'b1, 15'h0800 + 15'(k));
            settle();
            wait_toggle(2, gap);
            sum = 0;
            repeat (4) begin
                wait_toggle(2, gap);
                sum += gap;
            end
            chk_num("main_span", 4 * (2048 + k), sum);
        end
        for (int i = 0; i < 4; i++) begin
            cfg = CTL_CFG_RST;
            cfg.filter_amp_off = i[0];
            {cfg.pump_current_msb, cfg.pump_current_lsb} = 2'(i);
            {cfg.sw_c, cfg.sw_d, cfg.sw_e, cfg.sw_f, cfg.sw_g, cfg.sw_h} = pat_tab[i];
            i_fnd_host_model.send_ctl(cfg);
            settle();
            chk_bit("switches", 1'b1, sw === pat_tab[i]);
            chk_bit("amp_en", ~cfg.filter_amp_off, amp_en);
            chk_bit("pump_current", 1'b1, cur === 2'(i));
        end
        // Second reset mid-run, then a clean aligned start for the lock count
        gen_en <= 1'b0;
        rstn_i = 1'b0;
        repeat (20) @(negedge mclk_i);
        rstn_i = 1'b1;
        i_fnd_host_model.send_div(1'b0, 1'b1, 15'h0800);
        settle();
        chk_bit("div_running", 1'b1, running);
        gen_en <= 1'b1;
        repeat (13300) @(negedge mclk_i);
        chk_bit("lock_early", 1'b0, lock);
        repeat (2100) @(negedge mclk_i);
        chk_bit("lock", 1'b1, lock);
        i_fnd_host_model.send_div(1'b0, 1'b1, 15'h0801);
        repeat (9500) @(negedge mclk_i);
        chk_bit("lock_lost", 1'b0, lock);
        cfg = CTL_CFG_RST;
        cfg.pump_disable = 1'b1;
        i_fnd_host_model.send_ctl(cfg);
        settle();
        sum = 0;
        repeat (2500) begin
            @(negedge mclk_i);
            if (pump !== 2'h0 || lock !== 1'b0) begin
                sum++;
            end
        end
        chk_num("pump_active_cycles", 0, sum);
        wrap_up();
    end
endmodule
